//--- hdl/addr_window_decode.sv
`default_nettype none
// ==========================================
// One slave window of the master's decoder
module addr_window_decode #(
	parameter logic [ic_pkg::AW-1:0] BASE = '0,
	parameter int SPAN_BITS = 12,
	parameter logic SECURE_ONLY = 1'h0
) (
	dec_if.dec d
);
	// Base is span aligned, so only the upper bits are compared
	assign d.hit = (d.addr[ic_pkg::AW-1:SPAN_BITS] == BASE[ic_pkg::AW-1:SPAN_BITS])
		&& !(SECURE_ONLY && d.nonsecure);
	// Only the word bits inside the span go to the slave
	assign d.laddr = d.addr[SPAN_BITS-1:ic_pkg::WORD_BITS];
endmodule : addr_window_decode
`default_nettype wire

//--- hdl/dec_if.sv
`default_nettype none
// ==========================================
// Address window check between top and decoders
interface dec_if #(parameter int SAW = 10);
	logic [ic_pkg::AW-1:0] addr;
	logic nonsecure;
	logic hit;
	logic [SAW-1:0] laddr;
	modport dec (input addr, input nonsecure, output hit, output laddr);
	modport user (output addr, output nonsecure, input hit, input laddr);
endinterface : dec_if
`default_nettype wire

//--- hdl/ic_pkg.sv
`default_nettype none
package ic_pkg;
	// ==========================================
	// Widths
	localparam int AW = 32;
	localparam int MDW = 64;
	localparam int SDW = 32;
	localparam int LW = 8;
	localparam int SLW = 9;
	localparam int WORD_BITS = 2;
	localparam int NSLV = 2;

	// ==========================================
	// Response codes, lowest severity first in rank
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_EXOKAY = 2'h1;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	localparam logic [1:0] RANK_EXOKAY = 2'h0;
	localparam logic [1:0] RANK_OKAY = 2'h1;
	localparam logic [1:0] RANK_SLVERR = 2'h2;
	localparam logic [1:0] RANK_DECERR = 2'h3;

	// ==========================================
	// Memory map: each base is a multiple of its span
	localparam logic [AW-1:0] S0_BASE = 32'h0000_0000;
	localparam int S0_SPAN_BITS = 12;
	localparam logic [AW-1:0] S1_BASE = 32'h0001_0000;
	localparam int S1_SPAN_BITS = 16;
	localparam int S0_AW = S0_SPAN_BITS - WORD_BITS;
	localparam int S1_AW = S1_SPAN_BITS - WORD_BITS;
	localparam int LAW = S1_AW;

	// ==========================================
	// Topology options
	// Slave 1 is a bridge without response support
	localparam logic [NSLV-1:0] SLV_HAS_RESP = 2'h1;
	localparam logic [NSLV-1:0] SLV_SECURE_ONLY = 2'h2;
	localparam logic M_HAS_RESP = 1'h1;
	// Must be even so sub-bursts end on a wide beat boundary
	localparam logic [SLW-1:0] S_MAX_BURST = 9'h004;
	localparam logic [SLW-1:0] ONE_S = 9'h001;
	localparam logic [LW-1:0] ONE_W = 8'h01;
	localparam logic [LW-1:0] TWO_W = 8'h02;
	localparam logic [LAW-1:0] ONE_L = 14'h0001;
	localparam logic [NSLV-1:0] SEL_NONE = 2'h0;
	localparam logic [NSLV-1:0] SEL_S0 = 2'h1;
	localparam logic [NSLV-1:0] SEL_S1 = 2'h2;
endpackage : ic_pkg
`default_nettype wire

//--- hdl/mm_response_merge_addr_decode.sv
`default_nettype none
// Notes on behaviour
// - Split write responses merge into one
// - Narrow read responses merge per wide beat
// - Severity DECERR, SLVERR, OKAY, EXOKAY
// - Forward slave response when both support it
// - Interconnect answers OKAY for responseless slave
// - No responses anywhere if neither supports them
// - Responseless bridge: generate here, discard beyond
// - Illegal or insecure access goes to default
// - Select asserted when address in range, unless a nonsecure access hits a secure-only slave
// - Slave address trimmed to its span
// - Per-master decoding to each slave width
// - Base address multiple of span
module mm_response_merge_addr_decode (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic m_cmd_valid,
	output logic m_cmd_ready,
	input wire logic m_write,
	input wire logic [ic_pkg::AW-1:0] m_addr,
	input wire logic [ic_pkg::LW-1:0] m_len,
	input wire logic m_nonsecure,
	input wire logic m_wvalid,
	output logic m_wready,
	input wire logic [ic_pkg::MDW-1:0] m_wdata,
	output logic m_rvalid,
	input wire logic m_rready,
	output logic [ic_pkg::MDW-1:0] m_rdata,
	output logic [1:0] m_rresp,
	output logic m_rlast,
	output logic m_bvalid,
	input wire logic m_bready,
	output logic [1:0] m_bresp,
	output logic [ic_pkg::NSLV-1:0] s_sel,
	output logic [ic_pkg::S0_AW-1:0] s0_addr,
	output logic [ic_pkg::S1_AW-1:0] s1_addr,
	output logic s_cmd_valid,
	input wire logic s_cmd_ready,
	output logic s_write,
	output logic [ic_pkg::SLW-1:0] s_len,
	output logic s_wvalid,
	input wire logic s_wready,
	output logic [ic_pkg::SDW-1:0] s_wdata,
	output logic s_wlast,
	input wire logic s_rvalid,
	output logic s_rready,
	input wire logic [ic_pkg::SDW-1:0] s_rdata,
	input wire logic [1:0] s_rresp,
	input wire logic s_bvalid,
	output logic s_bready,
	input wire logic [1:0] s_bresp
);
	// ==========================================
	// Types and state
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_WR_CMD,
		ST_WR_DATA,
		ST_WR_RESP,
		ST_RD_CMD,
		ST_RD_DATA,
		ST_DEF_WR,
		ST_DEF_RD,
		ST_BRESP
	} state_t;

	typedef struct packed {
		state_t state;
		logic m_cmd_ready;
		logic m_wready;
		logic m_rvalid;
		logic m_rlast;
		logic m_bvalid;
		logic [ic_pkg::MDW-1:0] rdata;
		logic [1:0] rresp;
		logic [1:0] bresp;
		logic [ic_pkg::NSLV-1:0] sel;
		logic s_cmd_valid;
		logic s_write;
		logic [ic_pkg::SLW-1:0] s_len;
		logic s_wvalid;
		logic s_wlast;
		logic [ic_pkg::SDW-1:0] s_wdata;
		logic s_rready;
		logic s_bready;
		logic [ic_pkg::LAW-1:0] lw;
		logic [ic_pkg::SLW-1:0] remain;
		logic [ic_pkg::SLW-1:0] sub_left;
		logic [ic_pkg::LW-1:0] wide_left;
		logic [ic_pkg::MDW-1:0] wbuf;
		logic half;
	} regs_t;

	regs_t r;
	regs_t next_r;
	logic mrg_clr;
	logic mrg_en;
	logic [1:0] mrg_in;
	logic [1:0] mrg_worst;
	logic sel_resp;
	logic [ic_pkg::SLW-1:0] sub_len;

	// ==========================================
	// Decoding for this master, one window per slave
	dec_if #(.SAW(ic_pkg::S0_AW)) d0 ();
	dec_if #(.SAW(ic_pkg::S1_AW)) d1 ();
	assign d0.addr = m_addr;
	assign d0.nonsecure = m_nonsecure;
	assign d1.addr = m_addr;
	assign d1.nonsecure = m_nonsecure;

	addr_window_decode #(
		.BASE(ic_pkg::S0_BASE),
		.SPAN_BITS(ic_pkg::S0_SPAN_BITS),
		.SECURE_ONLY(ic_pkg::SLV_SECURE_ONLY[0])
	) u_dec0 (
		.d(d0)
	);

	addr_window_decode #(
		.BASE(ic_pkg::S1_BASE),
		.SPAN_BITS(ic_pkg::S1_SPAN_BITS),
		.SECURE_ONLY(ic_pkg::SLV_SECURE_ONLY[1])
	) u_dec1 (
		.d(d1)
	);

	resp_merge u_merge (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.clr(mrg_clr),
		.en(mrg_en),
		.resp_in(mrg_in),
		.worst(mrg_worst)
	);

	// ==========================================
	// Helpers
	// Slaves without responses are answered here; anything beyond is dropped
	assign sel_resp = |(r.sel & ic_pkg::SLV_HAS_RESP);
	// Next sub-burst never exceeds what the slave accepts
	assign sub_len = (r.remain > ic_pkg::S_MAX_BURST) ? ic_pkg::S_MAX_BURST : r.remain;

	// ==========================================
	// Transaction sequencer
	always_comb begin
		next_r = r;
		mrg_clr = 1'b0;
		mrg_en = 1'b0;
		mrg_in = ic_pkg::RESP_OKAY;
		case (r.state)
			ST_IDLE: begin
				next_r.m_cmd_ready = 1'b1;
				if (m_cmd_valid && r.m_cmd_ready) begin
					next_r.m_cmd_ready = 1'b0;
					next_r.remain = {m_len, 1'b0};
					next_r.wide_left = m_len;
					next_r.half = 1'b0;
					mrg_clr = 1'b1;
					if (d0.hit) begin
						next_r.sel = ic_pkg::SEL_S0;
						next_r.lw = {{(ic_pkg::LAW-ic_pkg::S0_AW){1'b0}}, d0.laddr};
					end else if (d1.hit) begin
						next_r.sel = ic_pkg::SEL_S1;
						next_r.lw = d1.laddr;
					end else begin
						next_r.sel = ic_pkg::SEL_NONE;
					end
					if (!d0.hit && !d1.hit) begin
						// Unmapped or insecure: default slave answers
						if (m_write) begin
							next_r.state = ST_DEF_WR;
							next_r.m_wready = 1'b1;
						end else begin
							next_r.state = ST_DEF_RD;
							next_r.m_rvalid = 1'b1;
							next_r.rdata = '0;
							next_r.rresp = ic_pkg::M_HAS_RESP ? ic_pkg::RESP_DECERR
								: ic_pkg::RESP_OKAY;
							next_r.m_rlast = (m_len == ic_pkg::ONE_W);
						end
					end else if (m_write) begin
						next_r.state = ST_WR_CMD;
						next_r.s_cmd_valid = 1'b1;
						next_r.s_write = 1'b1;
						next_r.s_len = ({m_len, 1'b0} > ic_pkg::S_MAX_BURST)
							? ic_pkg::S_MAX_BURST : {m_len, 1'b0};
						next_r.sub_left = next_r.s_len;
					end else begin
						// Reads go out as one narrow burst of twice the length
						next_r.state = ST_RD_CMD;
						next_r.s_cmd_valid = 1'b1;
						next_r.s_write = 1'b0;
						next_r.s_len = {m_len, 1'b0};
					end
				end
			end
			ST_WR_CMD: begin
				if (s_cmd_ready) begin
					next_r.s_cmd_valid = 1'b0;
					next_r.state = ST_WR_DATA;
					next_r.m_wready = 1'b1;
				end
			end
			ST_WR_DATA: begin
				// Wide word taken, then sent as low and high halves
				if (m_wvalid && r.m_wready) begin
					next_r.wbuf = m_wdata;
					next_r.m_wready = 1'b0;
					next_r.s_wvalid = 1'b1;
					next_r.s_wdata = m_wdata[ic_pkg::SDW-1:0];
					next_r.s_wlast = (r.sub_left == ic_pkg::ONE_S);
					next_r.half = 1'b0;
				end
				if (r.s_wvalid && s_wready) begin
					next_r.remain = r.remain - ic_pkg::ONE_S;
					next_r.sub_left = r.sub_left - ic_pkg::ONE_S;
					next_r.lw = r.lw + ic_pkg::ONE_L;
					if (r.sub_left == ic_pkg::ONE_S) begin
						next_r.s_wvalid = 1'b0;
						next_r.s_wlast = 1'b0;
						next_r.state = ST_WR_RESP;
						next_r.s_bready = sel_resp;
					end else if (!r.half) begin
						next_r.half = 1'b1;
						next_r.s_wdata = r.wbuf[ic_pkg::MDW-1:ic_pkg::SDW];
						next_r.s_wlast = (r.sub_left == (ic_pkg::ONE_S + ic_pkg::ONE_S));
					end else begin
						next_r.s_wvalid = 1'b0;
						next_r.m_wready = 1'b1;
					end
				end
			end
			ST_WR_RESP: begin
				// Each sub-burst adds its response to the running worst
				if (!sel_resp || (s_bvalid && r.s_bready)) begin
					next_r.s_bready = 1'b0;
					mrg_en = 1'b1;
					mrg_in = sel_resp ? s_bresp : ic_pkg::RESP_OKAY;
					if (r.remain == '0) begin
						// All sub-bursts answered, one merged reply
						if (ic_pkg::M_HAS_RESP) begin
							next_r.state = ST_BRESP;
							next_r.m_bvalid = 1'b1;
							next_r.bresp = mrg_worst;
						end else begin
							next_r.state = ST_IDLE;
							next_r.sel = ic_pkg::SEL_NONE;
						end
					end else begin
						next_r.state = ST_WR_CMD;
						next_r.s_cmd_valid = 1'b1;
						next_r.s_len = sub_len;
						next_r.sub_left = sub_len;
					end
				end
			end
			ST_RD_CMD: begin
				if (s_cmd_ready) begin
					next_r.s_cmd_valid = 1'b0;
					next_r.state = ST_RD_DATA;
					next_r.s_rready = 1'b1;
				end
			end
			ST_RD_DATA: begin
				if (s_rvalid && r.s_rready) begin
					next_r.lw = r.lw + ic_pkg::ONE_L;
					mrg_in = sel_resp ? s_rresp : ic_pkg::RESP_OKAY;
					if (!r.half) begin
						next_r.half = 1'b1;
						next_r.wbuf[ic_pkg::SDW-1:0] = s_rdata;
						mrg_clr = 1'b1;
						mrg_en = 1'b1;
					end else begin
						// Hold the slave off until the master takes this beat
						next_r.half = 1'b0;
						next_r.s_rready = 1'b0;
						next_r.m_rvalid = 1'b1;
						next_r.rdata = {s_rdata, r.wbuf[ic_pkg::SDW-1:0]};
						next_r.rresp = ic_pkg::M_HAS_RESP ? mrg_worst : ic_pkg::RESP_OKAY;
						next_r.m_rlast = (r.wide_left == ic_pkg::ONE_W);
						next_r.wide_left = r.wide_left - ic_pkg::ONE_W;
					end
				end
				if (r.m_rvalid && m_rready) begin
					next_r.m_rvalid = 1'b0;
					next_r.m_rlast = 1'b0;
					if (r.wide_left == '0) begin
						next_r.state = ST_IDLE;
						next_r.sel = ic_pkg::SEL_NONE;
					end else begin
						next_r.s_rready = 1'b1;
					end
				end
			end
			ST_DEF_WR: begin
				// Default slave swallows the data and then errors
				if (m_wvalid && r.m_wready) begin
					next_r.wide_left = r.wide_left - ic_pkg::ONE_W;
					if (r.wide_left == ic_pkg::ONE_W) begin
						next_r.m_wready = 1'b0;
						if (ic_pkg::M_HAS_RESP) begin
							next_r.state = ST_BRESP;
							next_r.m_bvalid = 1'b1;
							next_r.bresp = ic_pkg::RESP_DECERR;
						end else begin
							next_r.state = ST_IDLE;
						end
					end
				end
			end
			ST_DEF_RD: begin
				if (r.m_rvalid && m_rready) begin
					next_r.wide_left = r.wide_left - ic_pkg::ONE_W;
					next_r.m_rlast = (r.wide_left == ic_pkg::TWO_W);
					if (r.wide_left == ic_pkg::ONE_W) begin
						next_r.m_rvalid = 1'b0;
						next_r.m_rlast = 1'b0;
						next_r.state = ST_IDLE;
					end
				end
			end
			ST_BRESP: begin
				if (m_bready) begin
					next_r.m_bvalid = 1'b0;
					next_r.state = ST_IDLE;
					next_r.sel = ic_pkg::SEL_NONE;
				end
			end
			default: begin
				next_r = '0;
			end
		endcase
	end

	// Clock enable low freezes every register
	always_ff @(posedge clk) begin
		if (rst) begin
			r <= '0;
		end else if (ce) begin
			r <= next_r;
		end
	end

	// ==========================================
	// Outputs, all taken from flops
	assign m_cmd_ready = r.m_cmd_ready;
	assign m_wready = r.m_wready;
	assign m_rvalid = r.m_rvalid;
	assign m_rdata = r.rdata;
	assign m_rresp = r.rresp;
	assign m_rlast = r.m_rlast;
	assign m_bvalid = r.m_bvalid;
	assign m_bresp = r.bresp;
	assign s_sel = r.sel;
	assign s0_addr = r.lw[ic_pkg::S0_AW-1:0];
	assign s1_addr = r.lw[ic_pkg::S1_AW-1:0];
	assign s_cmd_valid = r.s_cmd_valid;
	assign s_write = r.s_write;
	assign s_len = r.s_len;
	assign s_wvalid = r.s_wvalid;
	assign s_wdata = r.s_wdata;
	assign s_wlast = r.s_wlast;
	assign s_rready = r.s_rready;
	assign s_bready = r.s_bready;
endmodule : mm_response_merge_addr_decode
`default_nettype wire

//--- hdl/resp_merge.sv
`default_nettype none
// ==========================================
// Keeps the most severe response of a group
module resp_merge (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic clr,
	input wire logic en,
	input wire logic [1:0] resp_in,
	output logic [1:0] worst
);
	logic [1:0] acc;
	logic [1:0] next_acc;

	function automatic logic [1:0] rank(input logic [1:0] r);
		case (r)
			ic_pkg::RESP_DECERR: rank = ic_pkg::RANK_DECERR;
			ic_pkg::RESP_SLVERR: rank = ic_pkg::RANK_SLVERR;
			ic_pkg::RESP_OKAY: rank = ic_pkg::RANK_OKAY;
			default: rank = ic_pkg::RANK_EXOKAY;
		endcase
	endfunction : rank

	// Worst of the kept value and the one arriving now
	assign worst = (rank(resp_in) > rank(acc)) ? resp_in : acc;

	// Clear restarts from the lowest rank so a lone response stands
	always_comb begin
		next_acc = acc;
		if (clr) begin
			next_acc = en ? resp_in : ic_pkg::RESP_EXOKAY;
		end else if (en) begin
			next_acc = worst;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			acc <= ic_pkg::RESP_EXOKAY;
		end else if (ce) begin
			acc <= next_acc;
		end
	end
endmodule : resp_merge
`default_nettype wire

//--- tb/mm_response_merge_addr_decode_test.sv
`default_nettype none
// ==========================================
// Random transactions to both windows and the default slave
module mm_response_merge_addr_decode_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst, ce, m_cmd_valid, m_cmd_ready, m_write, m_nonsecure, m_wvalid, m_wready;
	logic m_rvalid, m_rready, m_rlast, m_bvalid, m_bready, s_cmd_valid, s_cmd_ready, s_write;
	logic s_wvalid, s_wready, s_wlast, s_rvalid, s_rready, s_bvalid, s_bready, slow;
	logic [31:0] m_addr, s_wdata, s_rdata;
	logic [63:0] m_wdata, m_rdata;
	logic [7:0] m_len, codes;
	logic [1:0] m_rresp, m_bresp, s_rresp, s_bresp, s_sel;
	logic [9:0] s0_addr;
	logic [13:0] s1_addr;
	logic [8:0] s_len;
	int n_errors = 0;
	int num_checks = 0;
	mm_response_merge_addr_decode uut (.*);
	slave_model far (.*);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run
	task automatic chk(logic [63:0] s, logic [63:0] e, string nm);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// Ends at the edge where the flag is sampled high, bounded
	task automatic hs(ref logic s);
		int t;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (s !== 1'b1 && t < 300);
		if (t >= 300) begin
			n_errors++;
			complete_run();
		end
	endtask : hs
	function automatic logic [1:0] wst(logic [1:0] a, logic [1:0] b);
		return ((a[1] ? a : {1'b0, ~a[0]}) >= (b[1] ? b : {1'b0, ~b[0]})) ? a : b;
	endfunction : wst
	function automatic logic [1:0] cd(int k);
		return codes[2 * (k % 4) +: 2];
	endfunction : cd
	function automatic logic [31:0] pat(int k);
		return {24'hA50000, k[7:0]};
	endfunction : pat
	// One master transaction; t is 0 for slave 0, 1 for slave 1, 2 for default
	task automatic run(logic w, logic [31:0] a, logic [7:0] n, logic ns, int t);
		logic [1:0] e;
		m_write = w;
		m_addr = a;
		m_len = n;
		m_nonsecure = ns;
		m_cmd_valid = 1'b1;
		hs(m_cmd_ready);
		#1 m_cmd_valid = 1'b0;
		if (w) begin
			m_wvalid = 1'b1;
			for (int i = 0; i < n; i++) begin
				m_wdata = {$urandom, $urandom};
				hs(m_wready);
				#1;
			end
			m_wvalid = 1'b0;
			repeat ($urandom % 3) @(posedge clk);
			#1 m_bready = 1'b1;
			hs(m_bvalid);
			e = t == 0 ? ic_pkg::RESP_EXOKAY : t == 1 ? ic_pkg::RESP_OKAY : ic_pkg::RESP_DECERR;
			for (int j = 0; t == 0 && j < (n + 1) / 2; j++)
				e = wst(e, cd(j));
			chk(m_bresp, e, "bresp");
			#1 m_bready = 1'b0;
		end else begin
			m_rready = 1'b1;
			for (int i = 0; i < n; i++) begin
				hs(m_rvalid);
				e = t == 0 ? wst(cd(2 * i), cd(2 * i + 1)) :
					t == 1 ? ic_pkg::RESP_OKAY : ic_pkg::RESP_DECERR;
				chk(m_rresp, e, "rresp");
				chk(m_rdata, t == 2 ? 64'h0 : {pat(2 * i + 1), pat(2 * i)}, "rdata");
				chk(m_rlast, i == n - 1, "rlast");
				#1;
			end
			m_rready = 1'b0;
		end
	endtask : run
	// Corner cases first, then random mix; memory map bases are span multiples
	initial begin
		int kd;
		logic [31:0] a;
		{rst, ce} = 2'h3;
		{m_cmd_valid, m_write, m_nonsecure, m_wvalid, m_rready, m_bready, slow} = '0;
		{m_addr, m_wdata, m_len, codes} = '0;
		kd = $urandom(32'h33C7);
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		for (int i = 0; i < 60; i++) begin
			kd = i < 8 ? i % 4 : $urandom % 4;
			codes = i < 8 ? 8'hE4 : $urandom;
			slow = $urandom % 2;
			a = kd == 0 ? $urandom & 32'h0000_0EC0 :
				kd < 3 ? 32'h0001_0000 | ($urandom & 32'h0000_FFC0) :
				i == 3 ? 32'h0000_1000 : (32'h0002_0000 | $urandom) & 32'hFFFF_FFF8;
			run(i < 8 ? i / 4 : $urandom % 2, a, i < 8 ? 8'h05 : 8'h01 + $urandom % 6,
				kd == 2, kd > 1 ? 2 : kd);
		end
		complete_run();
	end
endmodule : mm_response_merge_addr_decode_test
`default_nettype wire

//--- tb/resp_checker.sv
`default_nettype none
// ==========================================
// Decode and response merge checks at the top ports
module resp_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic m_cmd_valid,
	input wire logic m_cmd_ready,
	input wire logic m_write,
	input wire logic [31:0] m_addr,
	input wire logic [7:0] m_len,
	input wire logic m_nonsecure,
	input wire logic m_wvalid,
	input wire logic m_wready,
	input wire logic [63:0] m_wdata,
	input wire logic m_rvalid,
	input wire logic [63:0] m_rdata,
	input wire logic [1:0] m_rresp,
	input wire logic m_bvalid,
	input wire logic [1:0] m_bresp,
	input wire logic [1:0] s_sel,
	input wire logic [9:0] s0_addr,
	input wire logic [13:0] s1_addr,
	input wire logic s_cmd_valid,
	input wire logic [8:0] s_len,
	input wire logic s_write,
	input wire logic s_wvalid,
	input wire logic s_wready,
	input wire logic [31:0] s_wdata,
	input wire logic s_rvalid,
	input wire logic s_rready,
	input wire logic [1:0] s_rresp,
	input wire logic s_bvalid,
	input wire logic s_bready,
	input wire logic [1:0] s_bresp
);
	logic [63:0] wd;
	logic whalf;
	logic [1:0] lo;
	logic [1:0] pw;
	logic [1:0] bw;
	logic half;
	wire take = m_cmd_valid && m_cmd_ready;
	wire h0 = m_addr[31:12] == 20'h0;
	wire h1 = m_addr[31:16] == 16'h0001 && !m_nonsecure;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Higher code wins except that OKAY outranks EXOKAY
	function automatic logic [1:0] wst(logic [1:0] a, logic [1:0] b);
		return ((a[1] ? a : {1'b0, ~a[0]}) >= (b[1] ? b : {1'b0, ~b[0]})) ? a : b;
	endfunction : wst
	// Track worst of each narrow pair and of all write sub-bursts
	always_ff @(posedge clk) begin
		if (rst || take) begin
			half <= 1'b0;
			whalf <= 1'b0;
			bw <= ic_pkg::RESP_EXOKAY;
		end else begin
			// Last wide beat taken, split into low then high narrow halves
			if (m_wvalid && m_wready)
				wd <= m_wdata;
			if (s_wvalid && s_wready)
				whalf <= !whalf;
			if (s_rvalid && s_rready) begin
				half <= !half;
				lo <= s_rresp;
				if (half)
					pw <= wst(lo, s_rresp);
			end
			if (s_bvalid && s_bready)
				bw <= wst(bw, s_bresp);
		end
	end
	// ==========================================
	// Assertions
	property p_sel0;
		take && h0 |=> s_sel == ic_pkg::SEL_S0 && s0_addr == $past(m_addr[11:2]);
	endproperty
	a_sel0: assert property (p_sel0) else $error("slave 0 select or address wrong");
	property p_sel1;
		take && h1 |=> s_sel == ic_pkg::SEL_S1 && s1_addr == $past(m_addr[15:2]);
	endproperty
	a_sel1: assert property (p_sel1) else $error("slave 1 select or address wrong");
	property p_dflt;
		take && !h0 && !h1 |=> (s_sel == ic_pkg::SEL_NONE && !s_cmd_valid) [*3];
	endproperty
	a_dflt: assert property (p_dflt) else $error("bad access reached a slave");
	property p_len;
		take && (h0 || h1) |=> s_write == $past(m_write) &&
			s_len == (($past(m_write) && $past(m_len) > 8'h02) ?
			9'h004 : {$past(m_len), 1'b0});
	endproperty
	a_len: assert property (p_len) else $error("slave length wrong");
	property p_rmrg;
		m_rvalid && s_sel == ic_pkg::SEL_S0 |-> m_rresp == pw;
	endproperty
	a_rmrg: assert property (p_rmrg) else $error("read response not merged");
	property p_rgen;
		m_rvalid && s_sel != ic_pkg::SEL_S0 |-> s_sel[1] ? m_rresp == ic_pkg::RESP_OKAY :
			m_rresp == ic_pkg::RESP_DECERR && m_rdata == 64'h0;
	endproperty
	a_rgen: assert property (p_rgen) else $error("generated read response wrong");
	property p_bmrg;
		m_bvalid && s_sel == ic_pkg::SEL_S0 |-> m_bresp == bw;
	endproperty
	a_bmrg: assert property (p_bmrg) else $error("write response not merged");
	property p_bgen;
		m_bvalid && s_sel != ic_pkg::SEL_S0 |->
			m_bresp == (s_sel[1] ? ic_pkg::RESP_OKAY : ic_pkg::RESP_DECERR);
	endproperty
	a_bgen: assert property (p_bgen) else $error("generated write response wrong");
	property p_last;
		$rose(m_bvalid) && s_sel == ic_pkg::SEL_S0 |-> $past(s_bvalid && s_bready);
	endproperty
	a_last: assert property (p_last) else $error("write answered before last sub-burst");
	property p_wdat;
		s_wvalid && s_wready |-> s_wdata == (whalf ? wd[63:32] : wd[31:0]);
	endproperty
	a_wdat: assert property (p_wdat) else $error("narrow write data wrong");
	c_s1w: cover property (take && h1 && m_write);
	c_err: cover property (m_bvalid && s_sel == ic_pkg::SEL_S0 && m_bresp == 2'h3);
	c_dfr: cover property (m_rvalid && s_sel == ic_pkg::SEL_NONE);
endmodule : resp_checker
bind mm_response_merge_addr_decode resp_checker chk (.*);
`default_nettype wire

//--- tb/slave_model.sv
`default_nettype none
// ==========================================
// Far side: one slave model serving whichever window is selected
module slave_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic [7:0] codes,
	input wire logic [1:0] s_sel,
	input wire logic s_cmd_valid,
	input wire logic s_write,
	input wire logic [8:0] s_len,
	input wire logic s_wvalid,
	input wire logic s_wlast,
	input wire logic s_rready,
	input wire logic s_bready,
	output logic s_cmd_ready,
	output logic s_wready,
	output logic s_rvalid,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_bvalid,
	output logic [1:0] s_bresp
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] k;
	logic [8:0] left;
	logic [1:0] code;
	logic go;
	// Idle lines show the inverse so a stale value never passes for data
	assign code = codes[2 * k[1:0] +: 2];
	assign s_rdata = s_rvalid ? {24'hA50000, k} : ~{24'hA50000, k};
	assign s_rresp = s_rvalid ? code : ~code;
	assign s_bresp = s_bvalid ? code : ~code;
	// State clears while nothing is selected, so each transaction starts at beat 0
	always @(posedge clk) begin
		go <= !(slow && $urandom % 2);
		if (rst || s_sel == 2'h0) begin
			{s_cmd_ready, s_wready, s_rvalid, s_bvalid, k, left} <= '0;
		end else begin
			s_cmd_ready <= s_cmd_valid && !s_cmd_ready && go;
			s_wready <= s_wvalid && !s_wready && go;
			if (s_cmd_valid && s_cmd_ready && !s_write)
				left <= s_len;
			if (s_rvalid && s_rready) begin
				left <= left - 9'h001;
				k <= k + 8'h01;
			end
			if (!s_rvalid || s_rready)
				s_rvalid <= left > {8'h00, s_rvalid} && go;
			// Responses stay up until taken, even where the path ignores them
			if (s_wvalid && s_wready && s_wlast) begin
				s_bvalid <= 1'b1;
			end else if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
				k <= k + 8'h01;
			end
		end
	end
endmodule : slave_model
`default_nettype wire
